// >>> dps_map.svh
`ifndef DPS_MAP_SVH
`define DPS_MAP_SVH
// ****************************************
// Pin levels and timing counts
// ****************************************
`define DPS_FLAG_COUNT 8
`define DPS_FLAG_FREE 1'b1
`define DPS_FLAG_TAKEN 1'b0
// Access phase lengths in ns, converted at 100 MHz
`define DPS_CLK_NS 10
`define DPS_SETUP_NS 20
`define DPS_STROBE_NS 30
`define DPS_GAP_NS 20
`define DPS_SETUP_CYC ((`DPS_SETUP_NS + `DPS_CLK_NS - 1) / `DPS_CLK_NS)
`define DPS_STROBE_CYC ((`DPS_STROBE_NS + `DPS_CLK_NS - 1) / `DPS_CLK_NS)
`define DPS_GAP_CYC ((`DPS_GAP_NS + `DPS_CLK_NS - 1) / `DPS_CLK_NS)
`endif

// >>> dps_pkg.sv
package dps_pkg;
    typedef enum logic [2:0] {
        DPS_IDLE = 3'h0,
        DPS_SETUP = 3'h1,
        DPS_STROBE = 3'h3,
        DPS_GAP = 3'h2,
        DPS_INIT = 3'h6
    } dps_state_t;
    typedef enum logic [1:0] {
        DPS_CMD_READ = 2'h0,
        DPS_CMD_WRITE = 2'h1,
        DPS_CMD_ACQUIRE = 2'h2,
        DPS_CMD_RELEASE = 2'h3
    } dps_cmd_t;
endpackage

// >>> dps_phase_timer.sv
`include "dps_map.svh"
module dps_phase_timer
    import dps_pkg::*;
#(
    parameter int W = 4
) (
    // Clock
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic ce,
    // Control
    input wire logic load,
    input wire logic [W-1:0] load_val,
    output logic done
);
    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;

    always_comb begin
        cnt_next = cnt_reg;
        if (load) begin
            cnt_next = load_val;
        end else if (cnt_reg != '0) begin
            cnt_next = cnt_reg - W'(1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cnt_reg <= '0;
        end else if (ce) begin
            cnt_reg <= cnt_next;
        end
    end

    assign done = (cnt_reg == W'(1)) || (cnt_reg == '0 && !load);
endmodule

// >>> dps_host.sv
`include "dps_map.svh"
module dps_host
    import dps_pkg::*;
#(
    parameter int DW = 18,
    parameter int AW = 18,
    parameter int TW = 4
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic ce,
    // Command port
    input wire logic cmd_valid,
    input wire dps_cmd_t cmd_op,
    input wire logic [2:0] cmd_flag,
    input wire logic cmd_value,
    input wire logic init_start,
    output logic cmd_ready,
    output logic rsp_valid,
    output logic rsp_flag,
    output logic rsp_granted,
    output logic rsp_consistent,
    // Device pins
    output logic flag_space_select_n,
    output logic mem_select_n,
    output logic write_n,
    output logic read_enable_n,
    output logic [1:0] byte_lane_selects_n,
    output logic [AW-1:0] flag_index_address,
    output logic [DW-1:0] data_out,
    output logic data_oe,
    input wire logic [DW-1:0] data_in
);
    // ****************************************
    // State
    // ****************************************
    dps_state_t st_reg, st_next;
    dps_cmd_t op_reg, op_next;
    logic is_wr_reg, is_wr_next;
    logic [2:0] idx_reg, idx_next;
    logic val_reg, val_next;
    logic init_reg, init_next;
    logic rsp_valid_reg, rsp_valid_next;
    logic rsp_flag_reg, rsp_flag_next;
    logic rsp_gr_reg, rsp_gr_next;
    logic rsp_cons_reg, rsp_cons_next;
    logic tmr_load;
    logic [TW-1:0] tmr_val;
    logic tmr_done;

    dps_phase_timer #(.W(TW)) u_timer (
        .clk_sys(clk_sys),
        .srst(srst),
        .ce(ce),
        .load(tmr_load),
        .load_val(tmr_val),
        .done(tmr_done)
    );

    // All bits agree only when the device replicated the flag
    function automatic logic all_same(input logic [DW-1:0] d);
        all_same = (d == '0) || (d == '1);
    endfunction

    // ****************************************
    // Sequencer
    // ****************************************
    always_comb begin
        st_next = st_reg;
        op_next = op_reg;
        is_wr_next = is_wr_reg;
        idx_next = idx_reg;
        val_next = val_reg;
        init_next = init_reg;
        rsp_valid_next = 1'b0;
        rsp_flag_next = rsp_flag_reg;
        rsp_gr_next = rsp_gr_reg;
        rsp_cons_next = rsp_cons_reg;
        tmr_load = 1'b0;
        tmr_val = TW'(`DPS_SETUP_CYC);
        case (st_reg)
            DPS_IDLE: begin
                if (init_start) begin
                    // Device does not clear flags itself
                    init_next = 1'b1;
                    idx_next = 3'h0;
                    val_next = `DPS_FLAG_FREE;
                    is_wr_next = 1'b1;
                    op_next = DPS_CMD_RELEASE;
                    st_next = DPS_SETUP;
                    tmr_load = 1'b1;
                end else if (cmd_valid) begin
                    op_next = cmd_op;
                    idx_next = cmd_flag;
                    // Acquire writes zero first, then reads back
                    case (cmd_op)
                        DPS_CMD_ACQUIRE: val_next = `DPS_FLAG_TAKEN;
                        DPS_CMD_RELEASE: val_next = `DPS_FLAG_FREE;
                        default: val_next = cmd_value;
                    endcase
                    is_wr_next = (cmd_op != DPS_CMD_READ);
                    st_next = DPS_SETUP;
                    tmr_load = 1'b1;
                end
            end
            DPS_SETUP: begin
                if (tmr_done) begin
                    st_next = DPS_STROBE;
                    tmr_load = 1'b1;
                    tmr_val = TW'(`DPS_STROBE_CYC);
                end
            end
            DPS_STROBE: begin
                if (tmr_done) begin
                    if (!is_wr_reg) begin
                        // Every data bit carries the flag
                        rsp_flag_next = data_in[0];
                        rsp_cons_next = all_same(data_in);
                        rsp_gr_next = (data_in[0] == `DPS_FLAG_TAKEN);
                    end
                    st_next = DPS_GAP;
                    tmr_load = 1'b1;
                    tmr_val = TW'(`DPS_GAP_CYC);
                end
            end
            DPS_GAP: begin
                // Select and output enable go inactive between accesses
                if (tmr_done) begin
                    if (op_reg == DPS_CMD_ACQUIRE && is_wr_reg && !val_reg) begin
                        is_wr_next = 1'b0;
                        st_next = DPS_SETUP;
                        tmr_load = 1'b1;
                    end else if (op_reg == DPS_CMD_ACQUIRE && !is_wr_reg && !rsp_gr_reg) begin
                        // Withdraw a lost request so no unwanted token arrives later
                        is_wr_next = 1'b1;
                        val_next = `DPS_FLAG_FREE;
                        st_next = DPS_SETUP;
                        tmr_load = 1'b1;
                    end else if (init_reg && idx_reg != 3'h7) begin
                        idx_next = idx_reg + 3'h1;
                        st_next = DPS_SETUP;
                        tmr_load = 1'b1;
                    end else begin
                        init_next = 1'b0;
                        rsp_valid_next = 1'b1;
                        if (is_wr_reg && op_reg != DPS_CMD_ACQUIRE) begin
                            rsp_flag_next = val_reg;
                            rsp_gr_next = 1'b0;
                            rsp_cons_next = 1'b1;
                        end
                        st_next = DPS_IDLE;
                    end
                end
            end
            default: begin
                st_next = DPS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st_reg <= DPS_IDLE;
            op_reg <= DPS_CMD_READ;
            is_wr_reg <= 1'b0;
            idx_reg <= 3'h0;
            val_reg <= 1'b1;
            init_reg <= 1'b0;
            rsp_valid_reg <= 1'b0;
            rsp_flag_reg <= 1'b1;
            rsp_gr_reg <= 1'b0;
            rsp_cons_reg <= 1'b0;
        end else if (ce) begin
            st_reg <= st_next;
            op_reg <= op_next;
            is_wr_reg <= is_wr_next;
            idx_reg <= idx_next;
            val_reg <= val_next;
            init_reg <= init_next;
            rsp_valid_reg <= rsp_valid_next;
            rsp_flag_reg <= rsp_flag_next;
            rsp_gr_reg <= rsp_gr_next;
            rsp_cons_reg <= rsp_cons_next;
        end
    end

    // ****************************************
    // Pins
    // ****************************************
    logic active;
    assign active = (st_reg == DPS_SETUP) || (st_reg == DPS_STROBE);
    assign cmd_ready = (st_reg == DPS_IDLE) && !init_start;
    assign rsp_valid = rsp_valid_reg;
    assign rsp_flag = rsp_flag_reg;
    assign rsp_granted = rsp_gr_reg;
    assign rsp_consistent = rsp_cons_reg;
    // Memory select held high so only flag space is touched
    assign mem_select_n = 1'b1;
    assign flag_space_select_n = !active;
    assign write_n = !(is_wr_reg && st_reg == DPS_STROBE);
    assign read_enable_n = !(!is_wr_reg && active);
    assign byte_lane_selects_n = active ? 2'h0 : 2'h3;
    // Higher address bits driven zero, the device ignores them
    assign flag_index_address = {{(AW-3){1'b0}}, idx_reg};
    // Value only on bit 0
    assign data_out = {{(DW-1){1'b0}}, val_reg};
    assign data_oe = is_wr_reg && active;

    // ****************************************
    // Checks
    // ****************************************
    sequence s_strobe_wr;
        (st_reg == DPS_STROBE) && is_wr_reg;
    endsequence

    property p_mem_off;
        @(posedge clk_sys) disable iff (srst) !flag_space_select_n |-> mem_select_n;
    endproperty
    a_mem_off: assert property (p_mem_off) else $error("memory select low in flag access");

    property p_bit0;
        @(posedge clk_sys) disable iff (srst) data_oe |-> (data_out[DW-1:1] == '0);
    endproperty
    a_bit0: assert property (p_bit0) else $error("upper data bits driven");

    property p_addr;
        @(posedge clk_sys) disable iff (srst)
            !flag_space_select_n |-> (flag_index_address[AW-1:3] == '0);
    endproperty
    a_addr: assert property (p_addr) else $error("high address bits not zero");

    property p_gap;
        @(posedge clk_sys) disable iff (srst || !ce)
            (st_reg == DPS_STROBE) ##1 (st_reg == DPS_GAP) |-> flag_space_select_n;
    endproperty
    a_gap: assert property (p_gap) else $error("select not released between accesses");

    property p_acq_readback;
        @(posedge clk_sys) disable iff (srst)
            (s_strobe_wr and (op_reg == DPS_CMD_ACQUIRE && !data_out[0]))
            |-> ##[1:20] (!read_enable_n);
    endproperty
    a_acq_readback: assert property (p_acq_readback) else $error("no read after acquire");

    property p_write_low;
        @(posedge clk_sys) disable iff (srst)
            !write_n |-> (!flag_space_select_n && data_oe && read_enable_n);
    endproperty
    a_write_low: assert property (p_write_low) else $error("write strobe outside access");

    property p_init_val;
        @(posedge clk_sys) disable iff (srst) (init_reg && data_oe) |-> data_out[0];
    endproperty
    a_init_val: assert property (p_init_val) else $error("init writes zero");
endmodule

// >>> dps_flag_model.sv
module dps_flag_model #(
    parameter int DW = 18,
    parameter int AW = 18
) (
    // Clock
    input wire logic clk_sys,
    // Host side pins
    input wire logic flag_space_select_n,
    input wire logic mem_select_n,
    input wire logic write_n,
    input wire logic read_enable_n,
    input wire logic [1:0] byte_lane_selects_n,
    input wire logic [AW-1:0] flag_index_address,
    input wire logic [DW-1:0] data_out,
    input wire logic data_oe,
    output logic [DW-1:0] data_in,
    // Opposite side
    input wire logic b_we,
    input wire logic [2:0] b_idx,
    input wire logic b_val,
    output logic [7:0] b_view
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Eight flags, no memory array behind them
    // ****************************************
    logic [7:0] req_a = 8'hA5;
    logic [7:0] req_b = 8'h3C;
    logic [7:0] own_a = 8'h00;
    logic [7:0] own_b = 8'h00;
    logic rd_cap = 1'b0;
    logic rd_was = 1'b0;
    logic acc, wr, rd_on;
    assign acc = !flag_space_select_n && mem_select_n;
    assign wr = acc && !write_n && data_oe;
    assign rd_on = acc && write_n && !read_enable_n && (byte_lane_selects_n != 2'h3);
    assign b_view = ~own_b;
    // Released lanes show the inverse so a late sample cannot pass by luck
    assign data_in[DW/2-1:0] = (rd_on && !byte_lane_selects_n[0]) ?
        {(DW/2){rd_cap}} : {(DW/2){~rd_cap}};
    assign data_in[DW-1:DW/2] = (rd_on && !byte_lane_selects_n[1]) ?
        {(DW-DW/2){rd_cap}} : {(DW-DW/2){~rd_cap}};
    always @(posedge clk_sys) begin
        logic [7:0] ra, rb, oa, ob;
        ra = req_a;
        rb = req_b;
        oa = own_a;
        ob = own_b;
        if (wr) ra[flag_index_address[2:0]] = data_out[0];
        if (b_we) rb[b_idx] = b_val;
        for (int i = 0; i < 8; i++) begin
            if (oa[i] && ra[i]) oa[i] = 1'b0;
            if (ob[i] && rb[i]) ob[i] = 1'b0;
            if (!oa[i] && !ob[i]) begin
                if (!ra[i]) oa[i] = 1'b1;
                else if (!rb[i]) ob[i] = 1'b1;
            end
        end
        req_a <= ra;
        req_b <= rb;
        own_a <= oa;
        own_b <= ob;
        // Capture only on a fresh read so the other side cannot disturb it
        if (rd_on && !rd_was) rd_cap <= ~own_a[flag_index_address[2:0]];
        rd_was <= rd_on;
    end
endmodule

// >>> dual_port_semaphore_flags_test.sv
`include "dps_map.svh"
module dual_port_semaphore_flags_test;
    timeunit 1ns;
    timeprecision 1ps;
    import dps_pkg::*;
    logic clk_sys, srst, ce, cmd_valid, cmd_value, init_start, b_we, b_val;
    dps_cmd_t cmd_op;
    logic [2:0] cmd_flag, b_idx;
    logic cmd_ready, rsp_valid, rsp_flag, rsp_granted, rsp_consistent;
    logic fs_n, ms_n, wr_n, re_n, oe;
    logic [1:0] bl_n;
    logic [17:0] addr, dout, din;
    logic [7:0] b_view;
    integer seed = 32'h2cd040dd;
    int error_cnt = 0;
    int cmp_count = 0;
    int cyc = 0;
    int f;
    dps_host #(.DW(18), .AW(18), .TW(4)) u_dps_host (.clk_sys(clk_sys), .srst(srst),
        .ce(ce), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_flag(cmd_flag),
        .cmd_value(cmd_value), .init_start(init_start), .cmd_ready(cmd_ready),
        .rsp_valid(rsp_valid), .rsp_flag(rsp_flag), .rsp_granted(rsp_granted),
        .rsp_consistent(rsp_consistent), .flag_space_select_n(fs_n), .mem_select_n(ms_n),
        .write_n(wr_n), .read_enable_n(re_n), .byte_lane_selects_n(bl_n),
        .flag_index_address(addr), .data_out(dout), .data_oe(oe), .data_in(din));
    dps_flag_model #(.DW(18), .AW(18)) u_dps_flag_model (.clk_sys(clk_sys),
        .flag_space_select_n(fs_n), .mem_select_n(ms_n), .write_n(wr_n),
        .read_enable_n(re_n), .byte_lane_selects_n(bl_n), .flag_index_address(addr),
        .data_out(dout), .data_oe(oe), .data_in(din), .b_we(b_we), .b_idx(b_idx),
        .b_val(b_val), .b_view(b_view));
    // ****************************************
    // Clock, timeout and shared tasks
    // ****************************************
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: run hung", $time);
            summarize();
        end
    end
    task automatic summarize();
        $display("errors %0d comparisons %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic check(input logic got, input logic exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask
    // Owner of a flag reads it low, everyone else high
    function automatic logic seen(input logic owned);
        return owned ? `DPS_FLAG_TAKEN : `DPS_FLAG_FREE;
    endfunction
    task automatic op(input dps_cmd_t o, input int fl, input logic v);
        @(negedge clk_sys);
        while (cmd_ready !== 1'b1) @(negedge clk_sys);
        @(posedge clk_sys);
        cmd_valid <= 1'b1;
        cmd_op <= o;
        cmd_flag <= fl[2:0];
        cmd_value <= v;
        @(posedge clk_sys);
        cmd_valid <= 1'b0;
        @(negedge clk_sys);
        while (rsp_valid !== 1'b1) @(negedge clk_sys);
    endtask
    task automatic b_wr(input int fl, input logic v);
        @(posedge clk_sys);
        b_we <= 1'b1;
        b_idx <= fl[2:0];
        b_val <= v;
        @(posedge clk_sys);
        b_we <= 1'b0;
        @(negedge clk_sys);
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {srst, ce} = 2'h3;
        {cmd_valid, cmd_value, init_start, b_we, b_val} = 5'h00;
        cmd_op = DPS_CMD_READ;
        {cmd_flag, b_idx} = 6'h00;
        repeat (20) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        init_start <= 1'b1;
        @(posedge clk_sys);
        init_start <= 1'b0;
        for (int i = 0; i < 8; i++) b_wr(i, 1'b1);
        for (int i = 0; i < 8; i++) begin
            op(DPS_CMD_READ, i, 1'b0);
            check(rsp_flag, seen(1'b0), "flag not free after init");
            check(rsp_consistent, 1'b1, "read not replicated");
        end
        // Stall the clock enable in the middle of an access
        fork
            op(DPS_CMD_READ, 3, 1'b0);
            begin
                repeat (4) @(posedge clk_sys);
                ce <= 1'b0;
                repeat (3) @(posedge clk_sys);
                ce <= 1'b1;
            end
        join
        check(rsp_flag, seen(1'b0), "read wrong across clock stall");
        check(rsp_consistent, 1'b1, "stalled read not replicated");
        repeat (6) begin
            f = $random(seed) & 7;
            op(DPS_CMD_ACQUIRE, f, 1'b0);
            check(rsp_granted, 1'b1, "free flag not granted");
            check(b_view[f], seen(1'b0), "other side sees taken");
            b_wr(f, 1'b1);
            op(DPS_CMD_READ, f, 1'b0);
            check(rsp_flag, seen(1'b1), "non-owner one freed flag");
            b_wr(f, 1'b0);
            op(DPS_CMD_READ, f, 1'b0);
            check(rsp_flag, seen(1'b1), "pending request stole flag");
            op(DPS_CMD_RELEASE, f, 1'b1);
            check(b_view[f], seen(1'b1), "no hand-over");
            op(DPS_CMD_ACQUIRE, f, 1'b0);
            check(rsp_granted, 1'b0, "owned flag granted");
            // No host write here: the lost request must already be withdrawn
            b_wr(f, 1'b1);
            op(DPS_CMD_READ, f, 1'b0);
            check(rsp_flag, seen(1'b0), "flag not free after release");
            fork
                op(DPS_CMD_ACQUIRE, f, 1'b0);
                begin
                    repeat ($unsigned($random(seed)) % 12) @(posedge clk_sys);
                    b_wr(f, 1'b0);
                end
            join
            repeat (2) @(negedge clk_sys);
            check(rsp_granted ^ (b_view[f] === 1'b0), 1'b1, "not one winner");
            op(DPS_CMD_WRITE, f, 1'b1);
            b_wr(f, 1'b1);
        end
        summarize();
    end
endmodule
